// ==== isc_pkg.sv ====
package isc_pkg;
  localparam logic [6:0] ISC_RLO_LSB_ADDR = 7'h08;
  localparam logic [6:0] ISC_RLO_MSB_ADDR = 7'h09;
  localparam logic [6:0] ISC_INT_CFG_ADDR = 7'h0A;
  localparam logic [6:0] ISC_MODE_ADDR = 7'h0B;
  localparam logic [6:0] ISC_AMP_ADDR = 7'h0C;
  localparam logic [6:0] ISC_LHI_LSB_ADDR = 7'h16;
  localparam logic [6:0] ISC_LHI_MSB_ADDR = 7'h17;
  localparam logic [7:0] ISC_ZERO_RST = 8'h00;
  localparam logic [7:0] ISC_MODE_RST = 8'h01;
  localparam int ISC_ROUTE_BIT = 7;
  localparam int ISC_RSVD_INT_BIT = 6;
  localparam int ISC_DOK_BIT = 0;
  localparam logic [5:0] ISC_SRC_HIRES_RDY = 6'h20;
  localparam logic [5:0] ISC_SRC_L_HYST = 6'h10;
  localparam logic [5:0] ISC_SRC_L_HI = 6'h08;
  localparam logic [5:0] ISC_SRC_R_HYST = 6'h02;
  localparam logic [5:0] ISC_SRC_R_HI = 6'h01;
  localparam logic [5:0] ISC_SRC_NONE = 6'h00;
  localparam logic [1:0] ISC_MODE_ACTIVE = 2'h0;
  localparam logic [1:0] ISC_MODE_SLEEP = 2'h1;
  localparam logic [1:0] ISC_MODE_SHUTDOWN = 2'h2;
  localparam int ISC_SCLK_DIV = 4;
  localparam logic [7:0] ISC_HADDR_CMD = 8'h00;
  localparam logic [7:0] ISC_HADDR_STAT = 8'h04;
  localparam logic [7:0] ISC_HADDR_RDATA = 8'h08;
endpackage : isc_pkg

// ==== isc_link_if.sv ====
`timescale 1ns/1ps
interface isc_link_if;
  logic sclk;
  logic csb;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  wire sdo = sdo_oe ? sdo_o : 1'b1;
  modport dev (input sclk, input csb, input sdi, output sdo_o,
    output sdo_oe);
  modport host (output sclk, output csb, output sdi, input sdo);
endinterface : isc_link_if

// ==== isc_sync.sv ====
`timescale 1ns/1ps
module isc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  initial begin
    if (WIDTH < 1) $error("isc_sync width");
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : isc_sync

// ==== isc_device.sv ====
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// - Low resistance threshold joins bytes 0x09,0x08
// - Writes accepted in any mode, active included
// - Bit 7 routes interrupt onto data-out
// - Sources: hi-res ready, L hysteresis, L high
// - Sources: R hysteresis, R high; zero none
// - Host uses only the six defined codes
// - Data-out shows source only with routing set; interrupt pin always does
// - Mode register resets 0x01, all bits stored as written
// - Mode 00 active, 01 sleep, 10 shutdown
// - Convert only when active; shutdown loses config
// - Host sets shutdown enable before shutdown
// - Bit0 zero needs regulation, one ignores it
// - L high threshold is 0x17*256 plus 0x16
// - L result above threshold sets flag
// - L low byte buffered until high written
// - R result below low threshold sets flag
// - R low byte buffered until high written
// - R high flag latches high, cleared by 0x00
module isc_device
  import isc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  isc_link_if.dev link,
  input wire logic [15:0] induct_result,
  input wire logic [15:0] resistance_result,
  input wire logic conversion_ready,
  input wire logic high_res_ready,
  input wire logic amplitude_ok,
  input wire logic shutdown_enable,
  output logic converting,
  output logic induct_high_compare_flag,
  output logic resist_hysteresis_flag,
  output logic resist_high_compare_flag,
  output logic [15:0] resist_low_threshold,
  output logic [15:0] induct_high_threshold,
  output logic interrupt_output
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } isc_dev_state_type;

  isc_dev_state_type state_q;
  logic [2:0] pins_s;
  logic sclk_s, csb_s, sdi_s, sclk_prev_q;
  logic [3:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0] rdata_q;
  logic [7:0] resist_low_thresh_lower_byte_q;
  logic [7:0] resist_low_thresh_upper_byte_q;
  logic [7:0] interrupt_routing_config_q;
  logic [7:0] functional_mode_config_q;
  logic [7:0] amplitude_control_config_q;
  logic [7:0] induct_high_thresh_lower_byte_q;
  logic [7:0] induct_high_thresh_upper_byte_q;
  logic [15:0] rlo_active_q, lhi_active_q;
  logic rise, fall, wr_done;
  logic [6:0] wr_addr;
  logic [7:0] wr_data, rd_mux;
  logic irq_level, l_hyst_q, shutdown_q, read_q;

  isc_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({link.sclk, link.csb, link.sdi}),
    .sync_out(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign csb_s = pins_s[1];
  assign sdi_s = pins_s[0];
  assign rise = sclk_s & ~sclk_prev_q;
  assign fall = ~sclk_s & sclk_prev_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // Frame: bit 15 read flag, 14:8 address, 7:0 data, MSB first
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0000;
      read_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          bit_cnt_q <= 4'h0;
          if (!csb_s) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (csb_s) begin
            state_q <= ST_IDLE;
          end else if (rise) begin
            shift_q <= {shift_q[14:0], sdi_s};
            // Read flag kept for the whole frame; the shifter moves on
            if (bit_cnt_q == 4'h0) begin
              read_q <= sdi_s;
            end
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'hF) begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          if (csb_s) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign wr_done = (state_q == ST_SHIFT) && rise && (bit_cnt_q == 4'hF)
    && !shift_q[14];
  assign wr_addr = shift_q[13:7];
  assign wr_data = {shift_q[6:0], sdi_s};

  // Any mode accepts writes; all bits stored as written
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resist_low_thresh_lower_byte_q <= ISC_ZERO_RST;
      resist_low_thresh_upper_byte_q <= ISC_ZERO_RST;
      interrupt_routing_config_q <= ISC_ZERO_RST;
      functional_mode_config_q <= ISC_MODE_RST;
      amplitude_control_config_q <= ISC_ZERO_RST;
      induct_high_thresh_lower_byte_q <= ISC_ZERO_RST;
      induct_high_thresh_upper_byte_q <= ISC_ZERO_RST;
      rlo_active_q <= 16'h0000;
      lhi_active_q <= 16'h0000;
    end else if (shutdown_q) begin
      // Shutdown drops configuration
      resist_low_thresh_lower_byte_q <= ISC_ZERO_RST;
      resist_low_thresh_upper_byte_q <= ISC_ZERO_RST;
      interrupt_routing_config_q <= ISC_ZERO_RST;
      functional_mode_config_q <= ISC_MODE_RST;
      amplitude_control_config_q <= ISC_ZERO_RST;
      induct_high_thresh_lower_byte_q <= ISC_ZERO_RST;
      induct_high_thresh_upper_byte_q <= ISC_ZERO_RST;
      rlo_active_q <= 16'h0000;
      lhi_active_q <= 16'h0000;
    end else if (wr_done) begin
      case (wr_addr)
        ISC_RLO_LSB_ADDR: resist_low_thresh_lower_byte_q <= wr_data;
        ISC_RLO_MSB_ADDR: begin
          resist_low_thresh_upper_byte_q <= wr_data;
          rlo_active_q <= {wr_data, resist_low_thresh_lower_byte_q};
        end
        ISC_INT_CFG_ADDR: interrupt_routing_config_q <= wr_data;
        ISC_MODE_ADDR: functional_mode_config_q <= wr_data;
        ISC_AMP_ADDR: amplitude_control_config_q <= wr_data;
        ISC_LHI_LSB_ADDR: induct_high_thresh_lower_byte_q <= wr_data;
        ISC_LHI_MSB_ADDR: begin
          induct_high_thresh_upper_byte_q <= wr_data;
          lhi_active_q <= {wr_data, induct_high_thresh_lower_byte_q};
        end
        default: ;
      endcase
    end
  end

  assign resist_low_threshold = rlo_active_q;
  assign induct_high_threshold = lhi_active_q;

  // Shutdown taken whenever the enable is high while shutdown mode is set
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shutdown_q <= 1'b0;
    end else begin
      shutdown_q <= shutdown_enable &&
        (functional_mode_config_q[1:0] == ISC_MODE_SHUTDOWN);
    end
  end

  assign converting = (functional_mode_config_q[1:0] == ISC_MODE_ACTIVE)
    && (amplitude_ok || amplitude_control_config_q[ISC_DOK_BIT]);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      induct_high_compare_flag <= 1'b0;
      resist_hysteresis_flag <= 1'b0;
      resist_high_compare_flag <= 1'b0;
      l_hyst_q <= 1'b0;
    end else begin
      if (converting && conversion_ready) begin
        induct_high_compare_flag <= induct_result > lhi_active_q;
        resist_hysteresis_flag <= resistance_result < rlo_active_q;
        l_hyst_q <= induct_result > lhi_active_q;
      end
      // Latched high event beats the clearing write
      if (converting && conversion_ready && resistance_result > rlo_active_q
          && interrupt_routing_config_q[5:0] == ISC_SRC_R_HI) begin
        resist_high_compare_flag <= 1'b1;
      end else if (wr_done && wr_addr == ISC_INT_CFG_ADDR
          && wr_data == ISC_ZERO_RST) begin
        resist_high_compare_flag <= 1'b0;
      end
    end
  end

  always_comb begin
    case (interrupt_routing_config_q[5:0])
      ISC_SRC_HIRES_RDY: irq_level = high_res_ready;
      ISC_SRC_L_HYST: irq_level = l_hyst_q;
      ISC_SRC_L_HI: irq_level = induct_high_compare_flag;
      ISC_SRC_R_HYST: irq_level = resist_hysteresis_flag;
      ISC_SRC_R_HI: irq_level = resist_high_compare_flag;
      default: irq_level = 1'b0;
    endcase
  end
  // Interrupt pin is active low
  assign interrupt_output = ~irq_level;

  always_comb begin
    // Last address bit is still on the input at the eighth rise
    case ({shift_q[5:0], sdi_s})
      ISC_RLO_LSB_ADDR: rd_mux = resist_low_thresh_lower_byte_q;
      ISC_RLO_MSB_ADDR: rd_mux = resist_low_thresh_upper_byte_q;
      ISC_INT_CFG_ADDR: rd_mux = interrupt_routing_config_q;
      ISC_MODE_ADDR: rd_mux = functional_mode_config_q;
      ISC_AMP_ADDR: rd_mux = amplitude_control_config_q;
      ISC_LHI_LSB_ADDR: rd_mux = induct_high_thresh_lower_byte_q;
      ISC_LHI_MSB_ADDR: rd_mux = induct_high_thresh_upper_byte_q;
      default: rd_mux = ISC_ZERO_RST;
    endcase
  end

  // Read data loads after 8th bit, shifts out on falling edges
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (state_q == ST_SHIFT && rise && bit_cnt_q == 4'h7) begin
      rdata_q <= rd_mux;
    end else if (state_q == ST_SHIFT && fall && bit_cnt_q > 4'h8) begin
      rdata_q <= {rdata_q[6:0], 1'b0};
    end
  end

  always_comb begin
    if (state_q != ST_IDLE) begin
      link.sdo_oe = read_q && bit_cnt_q >= 4'h8;
      link.sdo_o = rdata_q[7];
    end else begin
      link.sdo_oe = interrupt_routing_config_q[ISC_ROUTE_BIT];
      link.sdo_o = interrupt_output;
    end
  end
endmodule : isc_device

// ==== isc_host.sv ====
`timescale 1ns/1ps
module isc_host
  import isc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  isc_link_if.host link,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq_seen
);
  logic [7:0] addr_q;
  logic wr_q, busy_q, start_q, sdo_s;
  logic [15:0] frame_q;
  logic [7:0] rx_q;
  logic [4:0] bit_q;
  logic [1:0] div_q;
  logic sclk_q, csb_q;

  // Command word: bit 15 read, 14:8 device address, 7:0 data
  isc_sync #(.WIDTH(1)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(link.sdo),
    .sync_out(sdo_s)
  );
  assign hresp = 1'b0;
  assign hreadyout = 1'b1;
  assign link.sclk = sclk_q;
  assign link.csb = csb_q;
  assign link.sdi = frame_q[15];
  assign irq_seen = csb_q & ~sdo_s;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
    end else if (hready) begin
      addr_q <= haddr;
      wr_q <= hsel && htrans[1] && hwrite;
    end
  end

  always_comb begin
    case (addr_q)
      ISC_HADDR_STAT: hrdata = {31'h0000_0000, busy_q};
      ISC_HADDR_RDATA: hrdata = {24'h00_0000, rx_q};
      default: hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_q && addr_q == ISC_HADDR_CMD && !busy_q;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      frame_q <= 16'h0000;
      rx_q <= 8'h00;
      bit_q <= 5'h00;
      div_q <= 2'h0;
      sclk_q <= 1'b0;
      csb_q <= 1'b1;
    end else if (wr_q && addr_q == ISC_HADDR_CMD && !busy_q) begin
      busy_q <= 1'b1;
      frame_q <= hwdata[15:0];
      bit_q <= 5'h00;
      div_q <= 2'h0;
      csb_q <= 1'b0;
    end else if (busy_q && !start_q) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'(ISC_SCLK_DIV - 1)) begin
        if (bit_q == 5'h10) begin
          busy_q <= 1'b0;
          csb_q <= 1'b1;
        end else if (!sclk_q) begin
          sclk_q <= 1'b1;
        end else begin
          // Sample at the fall: two synchronisers delay data-out
          sclk_q <= 1'b0;
          rx_q <= {rx_q[6:0], sdo_s};
          frame_q <= {frame_q[14:0], 1'b0};
          bit_q <= bit_q + 5'h01;
        end
      end
    end
  end
endmodule : isc_host

// ==== isc_link_assertions.sv ====
`timescale 1ns/1ps
module isc_link_assertions
  import isc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdi,
  input wire logic sdo_oe
);
  logic sclk_q, csb_q, rd_q, rt_q;
  logic [4:0] n_q;
  logic [3:0] lo_q, hi_q;
  logic [15:0] sh_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Time spent with select low and high, saturating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      csb_q <= 1'b1;
      lo_q <= 4'h0;
      hi_q <= 4'h0;
    end else begin
      sclk_q <= sclk;
      csb_q <= csb;
      lo_q <= csb ? 4'h0 : lo_q + {3'h0, lo_q != 4'hf};
      hi_q <= !csb ? 4'h0 : hi_q + {3'h0, hi_q != 4'hf};
    end
  end
  // Frame decoder: bit count, read flag and shifted bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      n_q <= 5'h00;
      rd_q <= 1'b0;
      sh_q <= 16'h0000;
    end else if (csb) begin
      n_q <= 5'h00;
    end else if (sclk && !sclk_q) begin
      n_q <= n_q + 5'h01;
      sh_q <= {sh_q[14:0], sdi};
      if (n_q == 5'h00) rd_q <= sdi;
    end
  end
  // Routing bit of the last complete write to the interrupt config
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rt_q <= 1'b0;
    end else if (csb && !csb_q && n_q == 5'h10 && !sh_q[15]
                 && sh_q[14:8] == ISC_INT_CFG_ADDR) begin
      rt_q <= sh_q[7];
    end
  end
  a_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase wrong");
  a_sclk_low: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("sclk low phase short");
  a_sclk_idle: assert property (csb |-> !sclk)
    else $error("sclk moves outside frame");
  a_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("sdi changed while sclk high");
  a_frame_bits: assert property ($rose(csb) |-> n_q == 5'h10)
    else $error("frame not 16 bits");
  a_addr_quiet: assert property (
    !csb && lo_q > 4'h3 && n_q < 5'h08 |-> !sdo_oe)
    else $error("sdo driven in command bits");
  a_write_quiet: assert property (
    !csb && lo_q > 4'h3 && n_q != 5'h00 && !rd_q |-> !sdo_oe)
    else $error("sdo driven in write frame");
  a_read_drive: assert property (
    !csb && rd_q && n_q > 5'h09 && n_q < 5'h10 |-> sdo_oe)
    else $error("sdo not driven in read data");
  a_route_quiet: assert property (
    csb && hi_q > 4'h8 && !rt_q |-> !sdo_oe)
    else $error("sdo driven with routing off");
  a_route_drive: assert property (
    csb && hi_q > 4'h8 && rt_q |-> sdo_oe)
    else $error("sdo idle with routing on");
endmodule : isc_link_assertions

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import isc_pkg::*;
  logic clock, rst_b, hsel, hwrite, hreadyout, hresp, irq_seen;
  logic conv_rdy, hres_rdy, amp_ok, shut_en, conv, lhf, rhf, rrf, int_o;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata;
  logic [15:0] ind_r, res_r, rlt, iht;
  int num_errors, n_tests;
  isc_link_if isc_link_if_i ();
  isc_device isc_device_i (.clock(clock), .rst_b(rst_b),
    .link(isc_link_if_i), .induct_result(ind_r), .resistance_result(res_r),
    .conversion_ready(conv_rdy), .high_res_ready(hres_rdy),
    .amplitude_ok(amp_ok), .shutdown_enable(shut_en), .converting(conv),
    .induct_high_compare_flag(lhf), .resist_hysteresis_flag(rhf),
    .resist_high_compare_flag(rrf), .resist_low_threshold(rlt),
    .induct_high_threshold(iht), .interrupt_output(int_o));
  isc_host isc_host_i (.clock(clock), .rst_b(rst_b), .link(isc_link_if_i),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .irq_seen(irq_seen));
  isc_link_assertions isc_link_assertions_i (.clock(clock), .rst_b(rst_b),
    .sclk(isc_link_if_i.sclk), .csb(isc_link_if_i.csb),
    .sdi(isc_link_if_i.sdi), .sdo_oe(isc_link_if_i.sdo_oe));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task finish_test;
    $display("errors %0d compares %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    int k;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 99);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 99);
    r = hrdata;
    if (k >= 99) begin
      num_errors++;
      $display("mismatch at %0t: bus timeout", $time);
      finish_test;
    end
  endtask : ahb
  task xfer(input logic [15:0] f, output logic [7:0] rx);
    logic [31:0] r;
    int k;
    ahb(1'b1, ISC_HADDR_CMD, {16'h0000, f}, r);
    r = 32'h0000_0001;
    k = 0;
    while (r[0] !== 1'b0 && k < 400) begin
      ahb(1'b0, ISC_HADDR_STAT, 32'h0000_0000, r);
      k++;
    end
    if (k >= 400) begin
      num_errors++;
      $display("mismatch at %0t: frame timeout", $time);
      finish_test;
    end
    ahb(1'b0, ISC_HADDR_RDATA, 32'h0000_0000, r);
    rx = r[7:0];
  endtask : xfer
  task wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({1'b0, a, d}, x);
  endtask : wr
  task rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    xfer({1'b1, a, 8'h00}, d);
    chk({24'h0, d}, {24'h0, e});
  endtask : rchk
  task t_reset;
    rchk(ISC_RLO_MSB_ADDR, 8'h00);
    rchk(ISC_INT_CFG_ADDR, 8'h00);
    rchk(ISC_MODE_ADDR, 8'h01);
    rchk(ISC_AMP_ADDR, 8'h00);
    rchk(ISC_LHI_LSB_ADDR, 8'h00);
    chk(conv, 1'b0);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset
  task t_thresh;
    wr(ISC_MODE_ADDR, 8'h00);
    chk(conv, 1'b1);
    wr(ISC_RLO_LSB_ADDR, 8'h34);
    chk(rlt, 16'h0000);
    wr(ISC_RLO_MSB_ADDR, 8'h12);
    chk(rlt, 16'h1234);
    wr(ISC_LHI_LSB_ADDR, 8'h78);
    chk(iht, 16'h0000);
    rchk(ISC_LHI_LSB_ADDR, 8'h78);
    wr(ISC_LHI_MSB_ADDR, 8'h56);
    chk(iht, 16'h5678);
    ind_r <= 16'h5678;
    res_r <= 16'h1234;
    repeat (4) @(posedge clock);
    chk(lhf, 1'b0);
    chk(rhf, 1'b0);
    ind_r <= 16'h5679;
    res_r <= 16'h1233;
    repeat (4) @(posedge clock);
    chk(lhf, 1'b1);
    chk(rhf, 1'b1);
    $display("test thresholds done");
  endtask : t_thresh
  task t_amp;
    amp_ok <= 1'b0;
    repeat (2) @(posedge clock);
    chk(conv, 1'b0);
    wr(ISC_AMP_ADDR, 8'h01);
    chk(conv, 1'b1);
    wr(ISC_AMP_ADDR, 8'hfe);
    rchk(ISC_AMP_ADDR, 8'hfe);
    chk(conv, 1'b0);
    wr(ISC_AMP_ADDR, 8'h00);
    amp_ok <= 1'b1;
    $display("test amplitude done");
  endtask : t_amp
  task t_irq;
    logic [5:0] c [6];
    c = '{ISC_SRC_HIRES_RDY, ISC_SRC_L_HYST, ISC_SRC_L_HI, ISC_SRC_R_HYST,
          ISC_SRC_R_HI, ISC_SRC_NONE};
    hres_rdy <= 1'b1;
    wr(ISC_INT_CFG_ADDR, {2'b00, ISC_SRC_HIRES_RDY});
    chk(int_o, 1'b0);
    hres_rdy <= 1'b0;
    foreach (c[i]) begin
      wr(ISC_INT_CFG_ADDR, {2'b10, c[i]});
      rchk(ISC_INT_CFG_ADDR, {2'b10, c[i]});
    end
    repeat (12) @(posedge clock);
    chk(isc_link_if_i.sdo, 1'b1);
    wr(ISC_INT_CFG_ADDR, {2'b10, ISC_SRC_L_HI});
    repeat (12) @(posedge clock);
    chk(int_o, 1'b0);
    chk(isc_link_if_i.sdo, 1'b0);
    chk(irq_seen, 1'b1);
    wr(ISC_INT_CFG_ADDR, {2'b00, ISC_SRC_L_HI});
    repeat (12) @(posedge clock);
    chk(isc_link_if_i.sdo, 1'b1);
    chk(irq_seen, 1'b0);
    res_r <= 16'h1235;
    wr(ISC_INT_CFG_ADDR, {2'b00, ISC_SRC_R_HI});
    chk(int_o, 1'b0);
    chk(rrf, 1'b1);
    res_r <= 16'h1233;
    wr(ISC_INT_CFG_ADDR, 8'h00);
    chk(int_o, 1'b1);
    chk(rrf, 1'b0);
    $display("test interrupt done");
  endtask : t_irq
  task t_shut;
    shut_en <= 1'b1;
    wr(ISC_MODE_ADDR, {6'h00, ISC_MODE_SHUTDOWN});
    chk(conv, 1'b0);
    rchk(ISC_LHI_LSB_ADDR, 8'h00);
    $display("test shutdown done");
  endtask : t_shut
  initial begin
    rst_b = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ind_r = 16'h0000;
    res_r = 16'hffff;
    conv_rdy = 1'b1;
    hres_rdy = 1'b0;
    amp_ok = 1'b1;
    shut_en = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    t_reset;
    t_thresh;
    t_amp;
    t_irq;
    t_shut;
    finish_test;
  end
endmodule : tb_top
